// ==== rtl/conv_cfg.sv ====
// configuration, load sequencer and cascade alignment for the convolver
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module conv_cfg
  import conv_cfg_pkg::*;
#(
  parameter int unsigned EPROM_AW = 4,
  parameter int unsigned SETTLE   = 2
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // pins from outside, synchronised here
  input  wire logic                power_on_clear_b,
  input  wire logic                chip_select,
  input  wire logic                host_mode_select,
  input  wire logic                standalone_select_b,
  input  wire logic                primary_select_b,
  input  wire logic                host_strobe,
  input  wire logic                host_read,
  input  wire logic                first_line_skip,
  input  wire logic                cascade_ctrl_in,
  // host / eprom bus: address out, data two-way
  output logic [EPROM_AW+1:0]      eprom_addr,
  input  wire logic [7:0]          host_data_in,
  output logic [7:0]               host_data_out,
  output logic                     host_data_oe_b,
  input  wire logic [1:0]          host_reg_sel,
  output logic                     reply_out,
  output logic                     load_in_progress,
  // pixel and arithmetic datapath
  input  wire logic [7:0]          live_pixel_in,
  input  wire logic [7:0]          prev_field_pixel_in,
  input  wire logic [SUM_W-1:0]    internal_sum,
  input  wire logic [SUM_W-1:0]    expansion_in,
  input  wire logic [3:0]          gain_shift,
  output logic [15:0]              line_store_pixel,
  output logic                     field_odd,
  output logic [SUM_W-1:0]         expansion_out,
  output logic [OUT_W-1:0]         result_out,
  output logic                     result_saturation_flag,
  output logic [7:0]               delayed_pixel_out,
  // configuration seen by the rest of the device
  output logic [2:0]               array_mode,
  output logic [2:0]               line_len_mode,
  output logic                     cascade_limit16
);
  // two-flop synchronisers for all asynchronous pins
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= {cascade_ctrl_in, first_line_skip, host_read, host_strobe,
                    primary_select_b, standalone_select_b, host_mode_select, chip_select};
      sync2_reg <= sync1_reg;
    end
  end
  // clear pin: two sync flops plus one more for its rising edge
  logic [2:0] clr_sync_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) clr_sync_reg <= 3'h0;
    else        clr_sync_reg <= {clr_sync_reg[1:0], power_on_clear_b};
  end
  wire clr_n_s   = clr_sync_reg[1];
  wire clr_rise  = clr_sync_reg[1] & ~clr_sync_reg[2];
  wire cs_s      = sync2_reg[0];
  wire host_mode = sync2_reg[1];
  wire standalone = ~sync2_reg[2];
  wire strobe_s  = sync2_reg[4];
  wire rd_s      = sync2_reg[5];
  wire skip_s    = sync2_reg[6];
  logic cs_d_reg;
  logic strobe_d_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_d_reg     <= 1'b0;
      strobe_d_reg <= 1'b0;
    end else begin
      cs_d_reg     <= cs_s;
      strobe_d_reg <= strobe_s;
    end
  end
  wire cs_rise     = cs_s & ~cs_d_reg;
  wire strobe_rise = strobe_s & ~strobe_d_reg;

  // control registers A..D
  logic [7:0] regs_reg [NUM_REGS];
  logic [1:0] ld_idx_reg;
  logic [EPROM_AW-1:0] bank_reg;
  load_state_t ld_state_reg, ld_state_next;
  logic [3:0] ld_cnt_reg;
  wire ld_busy    = ld_state_reg != LD_IDLE;
  wire ld_capture = ld_state_reg == LD_DATA && ld_cnt_reg == 4'(SETTLE);
  wire ld_start   = !host_mode && (clr_rise || (cs_rise && clr_n_s));
  wire host_wr    = host_mode && strobe_rise && !rd_s && clr_n_s;
  wire host_rd    = host_mode && strobe_rise && rd_s;

  // eprom load sequencer: one address per register, settle, capture
  always_comb begin
    ld_state_next = ld_state_reg;
    unique case (ld_state_reg)
      LD_IDLE: if (ld_start) ld_state_next = LD_ADDR;
      LD_ADDR: ld_state_next = LD_DATA;
      LD_DATA: if (ld_capture) ld_state_next = (ld_idx_reg == REG_D) ? LD_IDLE : LD_ADDR;
      default: ld_state_next = LD_IDLE;   // unused code falls back to idle
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ld_state_reg <= LD_IDLE;
      ld_cnt_reg   <= 4'h0;
      ld_idx_reg   <= REG_A;
      bank_reg     <= '0;
    end else begin
      ld_state_reg <= ld_state_next;
      ld_cnt_reg   <= (ld_state_reg == LD_DATA && !ld_capture) ? ld_cnt_reg + 4'h1 : 4'h0;
      if (ld_start) ld_idx_reg <= REG_A;
      else if (ld_capture) ld_idx_reg <= ld_idx_reg + 2'h1;
      if (ld_start && cs_rise) bank_reg <= bank_reg + EPROM_AW'(1); // step to the next set on each chip select reload
    end
  end

  // register writes from eprom load or host strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_REGS; i++) regs_reg[i] <= REG_RESET;
    end else if (ld_capture) begin
      regs_reg[ld_idx_reg] <= host_data_in;
    end else if (host_wr) begin
      regs_reg[host_reg_sel] <= host_data_in;
    end
  end

  // host read-back and reply handshake; reply drops with the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_data_out    <= 8'h00;
      host_data_oe_b   <= 1'b1;
      reply_out        <= 1'b0;
      load_in_progress <= 1'b0;
      eprom_addr       <= '0;
    end else begin
      if (host_rd) host_data_out <= regs_reg[host_reg_sel];
      host_data_oe_b   <= ~(host_mode && strobe_s && rd_s);
      reply_out        <= host_mode && strobe_s && (strobe_d_reg || strobe_rise);
      load_in_progress <= ld_busy && !host_mode;
      eprom_addr       <= {bank_reg, ld_idx_reg};
    end
  end

  // configuration decode
  wire [2:0] mode_w      = regs_reg[REG_A][A_MODE_LSB +: 3];
  wire [1:0] field_sel_w = regs_reg[REG_C][C_FIELD_LSB +: 2];
  wire [1:0] ls_dly_w    = regs_reg[REG_D][D_LS_LSB +: 2];
  wire       split_w     = regs_reg[REG_D][D_SHIFT_BIT];
  wire       exp_dly_w   = regs_reg[REG_D][D_EXP_BIT];
  wire [2:0] line_len_w  = {regs_reg[REG_B][B_EXT_BIT], regs_reg[REG_B][2:1]};
  // cascade bits of register A only matter when cascaded
  wire [3:0] casc_bits_w = standalone ? 4'h0 : regs_reg[REG_A][3:0];

  // line store input delay: 0/4/8/12 clocks
  function automatic logic [3:0] ls_delay(input logic [1:0] code);
    ls_delay = 4'(code) << 2;
  endfunction
  logic [15:0] pix_pipe_reg [LS_MAX_DLY+1];
  wire  [15:0] pix_in_w = {prev_field_pixel_in, live_pixel_in};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i <= LS_MAX_DLY; i++) pix_pipe_reg[i] <= 16'h0000;
    end else begin
      pix_pipe_reg[0] <= pix_in_w;
      for (int i = 1; i <= LS_MAX_DLY; i++) pix_pipe_reg[i] <= pix_pipe_reg[i-1];
    end
  end

  // expansion input: optional four extra delays
  logic [SUM_W-1:0] exp_pipe_reg [EXP_LAT];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < EXP_LAT; i++) exp_pipe_reg[i] <= '0;
    end else begin
      exp_pipe_reg[0] <= expansion_in;
      for (int i = 1; i < EXP_LAT; i++) exp_pipe_reg[i] <= exp_pipe_reg[i-1];
    end
  end
  wire [SUM_W-1:0] exp_sel_w = exp_dly_w ? exp_pipe_reg[EXP_LAT-1] : expansion_in;

  // internal sum shift and expansion add; 16-bit limit at top rate
  wire [SUM_W-1:0] sum_sh_w  = split_w ? (internal_sum << SPLIT_SHIFT) : internal_sum;
  wire [SUM_W-1:0] total_w   = sum_sh_w + exp_sel_w;
  wire             lim16_w   = mode_w == MODE_40MHZ;
  wire [SUM_W-1:0] total_l_w = lim16_w ? {{(SUM_W-OUT_W){total_w[OUT_W-1]}}, total_w[OUT_W-1:0]} : total_w;

  // expansion output: four-clock inherent latency, the output flop being the last stage
  logic [SUM_W-1:0] xo_pipe_reg [EXP_LAT-1];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < EXP_LAT-1; i++) xo_pipe_reg[i] <= '0;
    end else begin
      xo_pipe_reg[0] <= total_l_w;
      for (int i = 1; i < EXP_LAT-1; i++) xo_pipe_reg[i] <= xo_pipe_reg[i-1];
    end
  end

  // field select and gain: top 16 bits of the shifted field
  wire [FIELD_W-1:0] field_w  = field_sel_w[0] ? total_l_w[FIELD_STEP +: FIELD_W] : total_l_w[FIELD_W-1:0];
  wire [FIELD_W+14:0] gained_w = {15'h0000, field_w} << gain_shift;
  wire                 ovf_w    = |gained_w[FIELD_W+14:FIELD_W];

  // delayed pixel output: base plus cascade extra from casc bits
  logic [7:0] del_pipe_reg [DEL_MAX];
  wire  [4:0] del_tap_w = 5'(DEL_BASE) + (casc_bits_w[0] ? 5'h04 : 5'h00)
                        + (casc_bits_w[1] ? 5'h10 : 5'h00);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEL_MAX; i++) del_pipe_reg[i] <= 8'h00;
    end else begin
      del_pipe_reg[0] <= live_pixel_in;
      for (int i = 1; i < DEL_MAX; i++) del_pipe_reg[i] <= del_pipe_reg[i-1];
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_store_pixel       <= 16'h0000;
      field_odd              <= 1'b0;
      expansion_out          <= '0;
      result_out             <= '0;
      result_saturation_flag <= 1'b0;
      delayed_pixel_out      <= 8'h00;
      array_mode             <= 3'h0;
      line_len_mode          <= 3'h0;
      cascade_limit16        <= 1'b0;
    end else begin
      line_store_pixel       <= pix_pipe_reg[ls_delay(ls_dly_w)];
      field_odd              <= skip_s;
      expansion_out          <= xo_pipe_reg[EXP_LAT-2];
      result_out             <= gained_w[FIELD_W-1 -: OUT_W];
      result_saturation_flag <= ovf_w;
      delayed_pixel_out      <= del_pipe_reg[del_tap_w - 5'h01];
      array_mode             <= mode_w;
      line_len_mode          <= line_len_w;
      cascade_limit16        <= lim16_w;
    end
  end

  // assertions
  a_reply_follows: assert property (@(posedge clk) disable iff (!rst_b)
    host_mode && strobe_rise |=> reply_out) else $error("reply missing");
  a_reply_drop: assert property (@(posedge clk) disable iff (!rst_b)
    !strobe_s |=> !reply_out) else $error("reply held without strobe");
  a_load_flag: assert property (@(posedge clk) disable iff (!rst_b)
    ld_start |-> ##2 load_in_progress) else $error("load flag missing");
  a_exp_latency: assert property (@(posedge clk) disable iff (!rst_b)
    ##4 1'b1 |-> expansion_out == $past(total_l_w, 4)) else $error("expansion latency");
  a_ls_eight: assert property (@(posedge clk) disable iff (!rst_b)
    ##12 ls_dly_w == 2'b10 && $stable(ls_dly_w) |=> line_store_pixel == $past(pix_in_w, 10))
    else $error("eight delay wrong");
  a_ovf_flag: assert property (@(posedge clk) disable iff (!rst_b)
    ovf_w |=> result_saturation_flag) else $error("overflow lost");
  c_eprom_load: cover property (@(posedge clk) disable iff (!rst_b) ld_start ##[1:60] !ld_busy);
  c_host_write: cover property (@(posedge clk) disable iff (!rst_b) host_wr);
  c_host_read:  cover property (@(posedge clk) disable iff (!rst_b) host_rd ##1 reply_out);
endmodule : conv_cfg
`default_nettype wire

// ==== rtl/conv_cfg_pkg.sv ====
// constants and types for the cascaded convolver configuration block
// Notes on behaviour
// - load_in_progress asserted during register load sequence
// - first_line_skip high bypasses first delay; interlaced marks field (here it bypasses no delay and only drives field_odd)
// - load after power_on_clear release; chip select reloads
// - extended pixels: low byte live, high previous
// - open host_mode_select pulls up to host mode
// - host_data_bus writes and reads back registers
// - reply_out acknowledges each host strobe
// - control A bits 6:4 set mode; 3:0 ignored standalone
// - control C bits 5:4 pick 20-bit result field (here only bit 4 counts: bits 23:4 or bits 19:0)
// - gain puts top 16 bits out; flag overflow
// - control B bits 2:1 line length, bit 3 offset (here bit 3 is the top bit of line_len_mode)
// - control D 3:2 01 four, 11 twelve clocks
// - control D 3:2 10 gives eight clocks
// - control D bit 1 shifts internal sum eight places
// - expansion out four clocks; D bit 0 adds four
// - above 20 MHz cascade precision limited to 16 bits
package conv_cfg_pkg;
  localparam int unsigned NUM_REGS      = 4;
  localparam logic [1:0]  REG_A         = 2'h0;
  localparam logic [1:0]  REG_B         = 2'h1;
  localparam logic [1:0]  REG_C         = 2'h2;
  localparam logic [1:0]  REG_D         = 2'h3;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam int unsigned A_MODE_LSB    = 4;
  localparam int unsigned C_FIELD_LSB   = 4;
  localparam int unsigned D_LS_LSB      = 2;
  localparam int unsigned D_SHIFT_BIT   = 1;
  localparam int unsigned D_EXP_BIT     = 0;
  localparam int unsigned B_EXT_BIT     = 3;
  localparam int unsigned FIELD_W       = 20;
  localparam int unsigned FIELD_STEP    = 4;
  localparam int unsigned OUT_W         = 16;
  localparam int unsigned SUM_W         = 32;
  localparam int unsigned SPLIT_SHIFT   = 8;
  localparam int unsigned EXP_LAT       = 4;
  localparam int unsigned LS_MAX_DLY    = 12;
  localparam int unsigned DEL_BASE      = 4;
  localparam int unsigned DEL_MAX       = 24;
  // mode code with a 16-bit cascade limit (above 20 MHz pixel rate)
  localparam logic [2:0]  MODE_40MHZ    = 3'h0;
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_ADDR = 2'b01,
    LD_DATA = 2'b10
  } load_state_t;
endpackage : conv_cfg_pkg

// ==== tb/conv_eprom_host.sv ====
// far side model: coefficient eprom plus host data drive on the shared bus
`timescale 1ns/1ps
`default_nettype none
module conv_eprom_host #(
  parameter int unsigned AW = 4
) (
  // clock
  input  wire logic          clk,
  // device side of the bus
  input  wire logic [AW+1:0] eprom_addr,
  input  wire logic [7:0]    host_data_out,
  input  wire logic          host_data_oe_b,
  // host side
  input  wire logic          host_mode,
  input  wire logic [7:0]    host_wdata,
  // resolved bus level
  output logic [7:0]         host_data_in
);
  logic [7:0] rom_q;
  // eprom answers one cycle after the address; bank plus one lands in bits 6:4
  always_ff @(posedge clk) begin
    // only register A carries a bank code; the rest, D bits 4:2 too, stay clear
    rom_q <= (eprom_addr[1:0] == 2'h0) ? {1'b0, eprom_addr[4:2] + 3'h1, 4'h0} : 8'h00;
  end
  // device drive wins; otherwise host or eprom owns the bus
  assign host_data_in = !host_data_oe_b ? host_data_out :
                        host_mode ? host_wdata : rom_q;
endmodule : conv_eprom_host
`default_nettype wire

// ==== tb/cascaded_convolver_config_tb.sv ====
// self-checking bench for the convolver configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module cascaded_convolver_config_tb;
  import conv_cfg_pkg::*;
  logic        clk = 0, rst_b = 0, poc_b = 1, cs = 0, hms = 1, sa_b = 1;
  logic        strobe = 0, rd = 0, fls = 0;
  logic [1:0]  sel = 0;
  logic [7:0]  wdata = 0, live = 0, prev = 0, din, dout, delp, q;
  logic [31:0] isum = 0, expin = 0, expout;
  logic [3:0]  gain = 0;
  logic [5:0]  eaddr;
  logic [15:0] lsp, res;
  logic [2:0]  amode, llm;
  logic        oe_b, reply, lip, fodd, sat, lim16;
  int          fails = 0, num_checks = 0, n0, n1, i;
  always #4 clk = ~clk;
  conv_cfg #(.EPROM_AW(4), .SETTLE(2)) dut (.clk(clk), .rst_b(rst_b), .power_on_clear_b(poc_b),
    .chip_select(cs), .host_mode_select(hms), .standalone_select_b(sa_b), .primary_select_b(1'b1),
    .host_strobe(strobe), .host_read(rd), .first_line_skip(fls), .cascade_ctrl_in(1'b0),
    .eprom_addr(eaddr), .host_data_in(din), .host_data_out(dout), .host_data_oe_b(oe_b),
    .host_reg_sel(sel), .reply_out(reply), .load_in_progress(lip), .live_pixel_in(live),
    .prev_field_pixel_in(prev), .internal_sum(isum), .expansion_in(expin), .gain_shift(gain),
    .line_store_pixel(lsp), .field_odd(fodd), .expansion_out(expout), .result_out(res),
    .result_saturation_flag(sat), .delayed_pixel_out(delp), .array_mode(amode),
    .line_len_mode(llm), .cascade_limit16(lim16));
  conv_eprom_host #(.AW(4)) far (.clk(clk), .eprom_addr(eaddr), .host_data_out(dout),
    .host_data_oe_b(oe_b), .host_mode(hms), .host_wdata(wdata), .host_data_in(din));
  // one host access: hold everything until reply is seen, then drop strobe
  task automatic hacc(input logic r, input logic [1:0] s, input logic [7:0] w);
    int k;
    @(posedge clk); strobe <= 1'b1; rd <= r; sel <= s; wdata <= w;
    for (k = 0; k < 40 && reply !== 1'b1; k++) begin @(posedge clk); #1; end
    if (k == 40) fails++;
    q = dout;
    if (r) `CHK(oe_b, 1'b0)
    @(posedge clk); strobe <= 1'b0; rd <= 1'b0;
    for (k = 0; k < 40 && reply !== 1'b0; k++) begin @(posedge clk); #1; end
    if (k == 40) fails++;
  endtask : hacc
  // clock edges after the first one until an input step arrives: 0 line store, 1 expansion, 2 delayed pixel
  task automatic lat(input int w, output int n);
    @(posedge clk);
    if (w != 1) begin live <= 8'h5a; prev <= 8'ha5; end else expin <= 32'h77;
    for (n = 0; n < 60; n++) begin
      @(posedge clk); #1;
      if (w == 0 ? lsp === 16'ha55a : w == 1 ? expout === 32'h77 : delp === 8'h5a) break;
    end
    if (n == 60) fails++;
    @(posedge clk); live <= 0; prev <= 0; expin <= 0;
    repeat (30) @(posedge clk);
  endtask : lat
  // bounded wait for the load flag to reach a level
  task automatic wait_lip(input logic v);
    int k;
    for (k = 0; k < 200 && lip !== v; k++) begin @(posedge clk); #1; end
    if (k == 200) fails++;
  endtask : wait_lip
  task automatic settle;
    repeat (30) @(posedge clk); #1;
  endtask : settle
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1; #1;
    `CHK(oe_b, 1'b1)
    `CHK(reply, 1'b0)
    repeat (4) @(posedge clk);
    // host writes every control register, then reads back A and B
    hacc(0, REG_A, 8'h5f); hacc(0, REG_B, 8'h0e); hacc(0, REG_C, 8'h00); hacc(0, REG_D, 8'h00);
    hacc(1, REG_A, 0); `CHK(q, 8'h5f)
    hacc(1, REG_B, 0); `CHK(q, 8'h0e)
    settle;
    `CHK(amode, 3'h5)
    `CHK(lim16, 1'b0)
    `CHK(llm, 3'h7)
    hacc(0, REG_A, 8'h0f); settle;
    `CHK(amode, 3'h0)
    `CHK(lim16, 1'b1)
    $display("host access test done");
    // line store pixel delay for every encoding, relative to encoding 00
    hacc(0, REG_D, 8'h00); lat(0, n0);
    for (i = 1; i < 4; i++) begin
      hacc(0, REG_D, 8'(i << 2)); lat(0, n1);
      `CHK(n1 - n0, 4 * i)
    end
    $display("line store delay test done");
    // expansion input extra delay and internal sum shift
    hacc(0, REG_D, 8'h00); lat(1, n0);
    `CHK(n0, EXP_LAT - 1)
    hacc(0, REG_D, 8'h01); lat(1, n1);
    `CHK(n1 - n0, 4)
    @(posedge clk); isum <= 32'h12; expin <= 32'h100;
    hacc(0, REG_D, 8'h02); settle;
    `CHK(expout, 32'h1300)
    hacc(0, REG_D, 8'h00); settle;
    `CHK(expout, 32'h112)
    // top rate mode keeps only sixteen bits, sign extended
    @(posedge clk); isum <= 32'h0001_8000; expin <= 0; settle;
    `CHK(expout, 32'hffff_8000)
    $display("expansion test done");
    // field select and gain onto the sixteen result pins, full precision mode
    hacc(0, REG_A, 8'h10);
    @(posedge clk); isum <= 32'h000a_bcde; expin <= 0;
    hacc(0, REG_C, 8'h00); settle;
    `CHK(res, 16'habcd)
    `CHK(sat, 1'b0)
    @(posedge clk); gain <= 4'h1; settle;
    `CHK(sat, 1'b1)
    @(posedge clk); gain <= 4'h0; hacc(0, REG_C, 8'h10); settle;
    `CHK(res, 16'h0abc)
    @(posedge clk); gain <= 4'h4; settle;
    `CHK(res, 16'habcd)
    `CHK(sat, 1'b0)
    $display("gain test done");
    // field marker follows the first line skip input
    @(posedge clk); fls <= 1'b1; repeat (6) @(posedge clk); #1;
    `CHK(fodd, 1'b1)
    @(posedge clk); fls <= 1'b0; repeat (6) @(posedge clk); #1;
    `CHK(fodd, 1'b0)
    $display("field test done");
    // delayed pixel output: cascade extras, ignored when standalone
    hacc(0, REG_A, 8'h10); lat(2, n0);
    hacc(0, REG_A, 8'h11); lat(2, n1);
    `CHK(n1 - n0, 4)
    hacc(0, REG_A, 8'h13); lat(2, n1);
    `CHK(n1 - n0, 20)
    @(posedge clk); sa_b <= 1'b0; settle;
    lat(2, n1);
    `CHK(n1 - n0, 0)
    $display("delayed pixel test done");
    // standalone eprom load after clear, then a chip select reload
    @(posedge clk); hms <= 1'b0; sa_b <= 1'b0; poc_b <= 1'b0;
    repeat (6) @(posedge clk);
    poc_b <= 1'b1;
    wait_lip(1'b1); `CHK(lip, 1'b1)
    wait_lip(1'b0); `CHK(amode, 3'h1)
    @(posedge clk); cs <= 1'b1;
    wait_lip(1'b1); wait_lip(1'b0);
    `CHK(amode, 3'h2)
    $display("eprom load test done");
    results();
  end
endmodule : cascaded_convolver_config_tb
`default_nettype wire
